// ===== hdl/low_power_mode_control.sv
/*
 low power mode controller: turns a core deep-sleep wait into stop or
 power-down, handles wake-up, debug clock keeping and timer freeze.
 assumes all pin-like inputs come from other domains; core, flash and
 peripheral bus handshakes are on clk_i. registers over classic wishbone.
*/
`timescale 1ns/10ps
module low_power_mode_control
   import lpm_pkg::*;
#(
   parameter int REG_START_CYCLES  = REG_START_CYC,
   parameter int FLASH_WAKE_CYCLES = FLASH_WAKE_CYC,
   parameter int FLASH_FAST_CYCLES = FLASH_FAST_CYC
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        deep_sleep_request_i,
   input  wire logic        core_wait_i,
   input  wire logic        core_halted_i,
   input  wire logic        flash_busy_i,
   input  wire logic        bus_busy_i,
   input  wire logic        io_wake_i,
   input  wire logic        wake_timer_evt_i,
   input  wire logic        detector_raw_i,
   input  wire logic        slow_osc_tick_i,
   input  wire logic        reset_pin_i,
   input  wire logic        wake_pin0_i,
   input  wire logic        wake_pin1_i,
   output logic             core_clk_en_o,
   output logic             core_resume_o,
   output logic             periph_clk_en_o,
   output logic             fast_internal_osc_en_o,
   output logic             slow_internal_osc_en_o,
   output logic             sysclk_sel_fast_o,
   output logic             flash_deep_sleep_o,
   output logic             io_hold_o,
   output logic             io_float_o,
   output logic             regulator_en_o,
   output logic             regulator_low_power_o,
   output logic             regulator_level_o,
   output logic             digital_supply_en_o,
   output logic             watchdog_run_o,
   output logic             por_request_o,
   output logic             event_line18_o,
   output logic             detector_irq_en_o,
   output logic [3:0]       freeze_o
);
   import lpm_pkg::*;

   initial begin
      if (REG_START_CYCLES < 1 || FLASH_WAKE_CYCLES < 1 ||
          FLASH_FAST_CYCLES < 1 || REG_START_CYCLES >= 2**CNT_W ||
          FLASH_WAKE_CYCLES >= 2**CNT_W || FLASH_FAST_CYCLES >= 2**CNT_W)
         $error("wake delay parameters out of range");
   end

   pm_state_t   state_q;
   logic [31:0] pctl_q, psts_q, vrst_q, osc_q, flash_q, rsel_q, ren_q, dbg_q;
   logic        wake_flag_q, dbgpd_flag_q;
   logic [CNT_W-1:0] cnt_q;
   logic        go_pd_q, wd_on_q;
   logic [2:0]  s_rst_q, s_w0_q, s_w1_q, s_det_q, s_tick_q, s_io_q;
   logic        rst_pin_q, w0_q, w1_q, det_q, tick_q, io_q;
   logic        det_filt_q;
   logic [7:0]  filt_cnt_q;
   logic        wake_evt, pd_wake, access, wr, stop_sel;
   logic        keep_stop, keep_pd;

   // three-stage sync; change accepted when stages two and three agree
   always_ff @(posedge clk_i) begin
      s_rst_q  <= {s_rst_q[1:0],  reset_pin_i};
      s_w0_q   <= {s_w0_q[1:0],   wake_pin0_i};
      s_w1_q   <= {s_w1_q[1:0],   wake_pin1_i};
      s_det_q  <= {s_det_q[1:0],  detector_raw_i};
      s_tick_q <= {s_tick_q[1:0], slow_osc_tick_i};
      s_io_q   <= {s_io_q[1:0],   io_wake_i};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_pin_q <= 1'b1;
         w0_q      <= 1'b0;
         w1_q      <= 1'b0;
         det_q     <= 1'b0;
         tick_q    <= 1'b0;
         io_q      <= 1'b0;
      end else begin
         if (s_rst_q[2] == s_rst_q[1])   rst_pin_q <= s_rst_q[2];
         if (s_w0_q[2] == s_w0_q[1])     w0_q      <= s_w0_q[2];
         if (s_w1_q[2] == s_w1_q[1])     w1_q      <= s_w1_q[2];
         if (s_det_q[2] == s_det_q[1])   det_q     <= s_det_q[2];
         if (s_tick_q[2] == s_tick_q[1]) tick_q    <= s_tick_q[2];
         if (s_io_q[2] == s_io_q[1])     io_q      <= s_io_q[2];
      end
   end

   // detector filter counted in slow-osc periods
   wire tick_rise = s_tick_q[2] == s_tick_q[1] && s_tick_q[2] && !tick_q;
   wire [7:0] filt_n = pctl_q[BIT_FILT_CNT_LO +: 8];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         det_filt_q <= 1'b0;
         filt_cnt_q <= 8'h00;
      end else if (!pctl_q[BIT_DET_EN]) begin
         det_filt_q <= 1'b0;
         filt_cnt_q <= 8'h00;
      end else if (!pctl_q[BIT_FILT_EN] || filt_n == 8'h00) begin
         det_filt_q <= det_q;
         filt_cnt_q <= 8'h00;
      end else if (det_q == det_filt_q) begin
         filt_cnt_q <= 8'h00;
      end else if (tick_rise) begin
         if (filt_cnt_q + 8'h01 >= filt_n) begin
            det_filt_q <= det_q;
            filt_cnt_q <= 8'h00;
         end else begin
            filt_cnt_q <= filt_cnt_q + 8'h01;
         end
      end
   end

   // wishbone decode; ack one cycle after the strobe, dropped next cycle
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr     = access && wb_we_i;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel,
                                         input logic [31:0] msk);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
      return r & msk;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         if (access && !wb_we_i) begin
            unique case (wb_adr_i)
               OFS_POWER_CONTROL:   wb_dat_o <= pctl_q;
               OFS_POWER_STATUS:    wb_dat_o <= psts_q |
                  (32'(wake_flag_q) << BIT_WAKE_FLAG) |
                  (32'(dbgpd_flag_q) << BIT_DBGPD_FLAG) |
                  (32'(det_filt_q) << BIT_DET_OUT);
               OFS_VOLTAGE_RESET:   wb_dat_o <= vrst_q;
               OFS_OSC_CONTROL:     wb_dat_o <= osc_q;
               OFS_FLASH_POWER:     wb_dat_o <= flash_q;
               OFS_STOP_REG_SELECT: wb_dat_o <= rsel_q;
               OFS_STOP_REG_ENABLE: wb_dat_o <= ren_q;
               OFS_DEBUG_FREEZE:    wb_dat_o <= dbg_q;
               default:             wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // register writes; power-down wake comes through rst_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pctl_q  <= RST_POWER_CONTROL;
         psts_q  <= RST_POWER_STATUS;
         vrst_q  <= RST_VOLTAGE_RESET;
         osc_q   <= RST_OSC_CONTROL;
         flash_q <= 32'h0000_0000;
         rsel_q  <= RST_STOP_REG_SEL;
         ren_q   <= 32'h0000_0000;
         dbg_q   <= 32'h0000_0000;
      end else if (wr) begin
         unique case (wb_adr_i)
            OFS_POWER_CONTROL:   pctl_q <= merge(pctl_q, wb_dat_i,
                                    wb_sel_i, MSK_POWER_CONTROL);
            OFS_POWER_STATUS:    psts_q <= merge(psts_q, wb_dat_i,
                                    wb_sel_i, MSK_POWER_STATUS);
            OFS_VOLTAGE_RESET:   vrst_q <= merge(vrst_q, wb_dat_i,
                                    wb_sel_i, 32'hff00_ffff);
            OFS_OSC_CONTROL:     osc_q <= merge(osc_q, wb_dat_i,
                                    wb_sel_i, 32'h0000_0fe0);
            OFS_FLASH_POWER:     flash_q <= merge(flash_q, wb_dat_i,
                                    wb_sel_i, MSK_FLASH_POWER);
            OFS_STOP_REG_SELECT: rsel_q <= merge(rsel_q, wb_dat_i,
                                    wb_sel_i, MSK_STOP_REG);
            OFS_STOP_REG_ENABLE: ren_q <= merge(ren_q, wb_dat_i,
                                    wb_sel_i, MSK_STOP_REG);
            OFS_DEBUG_FREEZE:    dbg_q <= merge(dbg_q, wb_dat_i,
                                    wb_sel_i, MSK_DEBUG_FREEZE);
            default: ;
         endcase
      end else begin
         // clear bits never pass MSK_POWER_CONTROL on a write, so they stay zero
         pctl_q[BIT_CLR_WAKE]  <= 1'b0;
         pctl_q[BIT_CLR_DBGPD] <= 1'b0;
      end
   end

   assign stop_sel  = pctl_q[BIT_STOP_PD_SEL];
   assign keep_stop = dbg_q[BIT_DBG_KEEP_STOP];
   assign keep_pd   = dbg_q[BIT_DBG_KEEP_PD];
   // stop wake sources; the core only waits with nothing pending
   assign wake_evt  = io_q || wake_timer_evt_i || det_filt_q ||
                      !rst_pin_q;
   // wake pin edges, polarity picks rising or falling
   wire w0_edge = (s_w0_q[2] == s_w0_q[1]) && (s_w0_q[2] != w0_q) &&
                  (s_w0_q[2] == psts_q[BIT_WAKE_POL]);
   wire w1_edge = (s_w1_q[2] == s_w1_q[1]) && (s_w1_q[2] != w1_q) &&
                  (s_w1_q[2] == psts_q[BIT_WAKE_POL]);
   wire rp_edge = (s_rst_q[2] == s_rst_q[1]) && (s_rst_q[2] != rst_pin_q) &&
                  (s_rst_q[2] == pctl_q[BIT_RST_PIN_POL]);
   assign pd_wake = rp_edge || (w0_edge && psts_q[BIT_WAKE0_EN]) ||
                    (w1_edge && psts_q[BIT_WAKE1_EN]);

   // sticky flags; MSK_POWER_CONTROL masks off the clear bits, so only rst_i clears them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_flag_q  <= 1'b0;
         dbgpd_flag_q <= 1'b0;
      end else begin
         if (state_q == ST_STOP && wake_evt)
            wake_flag_q <= 1'b1;
         else if (pctl_q[BIT_CLR_WAKE])
            wake_flag_q <= 1'b0;
         if (state_q == ST_PD && keep_pd)
            dbgpd_flag_q <= 1'b1;
         else if (pctl_q[BIT_CLR_DBGPD])
            dbgpd_flag_q <= 1'b0;
      end
   end

   // power mode sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_RUN;
         go_pd_q <= 1'b0;
         cnt_q   <= '0;
      end else begin
         unique case (state_q)
            ST_RUN: if (core_wait_i && deep_sleep_request_i) begin
               go_pd_q <= stop_sel;
               state_q <= ST_DRAIN;
            end
            ST_DRAIN: if (!flash_busy_i && !bus_busy_i) begin
               state_q <= go_pd_q ? ST_PD : ST_STOP;
            end
            ST_STOP: if (wake_evt) begin
               cnt_q   <= CNT_W'(REG_START_CYCLES - 1);
               state_q <= ST_REG_UP;
            end
            ST_REG_UP: if (cnt_q == '0) begin
               cnt_q   <= flash_q[BIT_FAST_FLASH_WAKE] ?
                          CNT_W'(FLASH_FAST_CYCLES - 1) :
                          CNT_W'(FLASH_WAKE_CYCLES - 1);
               state_q <= ST_FLASH_UP;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            ST_FLASH_UP: if (cnt_q == '0) begin
               state_q <= ST_RUN;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            ST_PD: ; // left only by por_request_o reset
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // power-down exit requests a full reset of the device
   always_ff @(posedge clk_i) begin
      if (rst_i)
         por_request_o <= 1'b0;
      else
         por_request_o <= state_q == ST_PD && pd_wake;
   end

   // watchdog latches on once enabled, runs through stop
   always_ff @(posedge clk_i) begin
      if (rst_i)
         wd_on_q <= 1'b0;
      else if (pctl_q[BIT_WDG_RST_EN])
         wd_on_q <= 1'b1;
   end

   // registered power outputs from state and configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_clk_en_o          <= 1'b1;
         core_resume_o          <= 1'b0;
         periph_clk_en_o        <= 1'b1;
         fast_internal_osc_en_o <= 1'b1;
         slow_internal_osc_en_o <= 1'b1;
         sysclk_sel_fast_o      <= 1'b1;
         flash_deep_sleep_o     <= 1'b0;
         io_hold_o              <= 1'b0;
         io_float_o             <= 1'b0;
         regulator_en_o         <= 1'b1;
         regulator_low_power_o  <= 1'b0;
         regulator_level_o      <= 1'b0;
         digital_supply_en_o    <= 1'b1;
         watchdog_run_o         <= 1'b0;
         event_line18_o         <= 1'b0;
         detector_irq_en_o      <= 1'b0;
         freeze_o               <= 4'h0;
      end else begin
         core_clk_en_o <= (state_q == ST_STOP) ? keep_stop :
                          (state_q == ST_PD)   ? keep_pd : 1'b1;
         core_resume_o <= state_q == ST_FLASH_UP && cnt_q == '0;
         periph_clk_en_o <= !(state_q == ST_STOP || state_q == ST_PD);
         fast_internal_osc_en_o <= (state_q == ST_STOP) ? keep_stop :
                                   (state_q == ST_PD) ? keep_pd : 1'b1;
         slow_internal_osc_en_o <= (state_q == ST_PD) ? 1'b0 :
                                   osc_q[BIT_SLOW_OSC_EN];
         sysclk_sel_fast_o  <= 1'b1;
         // flash stays asleep until the regulator start-up delay ends
         flash_deep_sleep_o <= state_q == ST_STOP || state_q == ST_PD ||
                               state_q == ST_REG_UP;
         io_hold_o  <= state_q == ST_STOP;
         io_float_o <= state_q == ST_PD;
         regulator_en_o <= state_q != ST_PD || keep_pd;
         regulator_low_power_o <= state_q == ST_STOP && !keep_stop;
         regulator_level_o     <= rsel_q[BIT_STOP_REG_LVL];
         digital_supply_en_o   <= state_q != ST_PD || keep_pd;
         watchdog_run_o <= wd_on_q &&
                           !(core_halted_i && dbg_q[BIT_FRZ_WDG]);
         event_line18_o    <= det_filt_q;
         detector_irq_en_o <= pctl_q[BIT_DET_IRQ_EN];
         freeze_o <= core_halted_i ? {dbg_q[BIT_FRZ_WAKE_TMR],
                     dbg_q[BIT_FRZ_TIMER_B], dbg_q[BIT_FRZ_TIMER_A],
                     dbg_q[BIT_FRZ_WDG]} : 4'h0;
      end
   end
endmodule

// ===== hdl/lpm_pkg.sv
/*
 low power mode controller package: register offsets, field positions,
 reset values and timing counts.
 assumes a 100 MHz system clock and a 32-bit wishbone register bus.
*/
package lpm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_POWER_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_POWER_STATUS    = 8'h04;
   localparam logic [7:0] OFS_VOLTAGE_RESET   = 8'h08;
   localparam logic [7:0] OFS_OSC_CONTROL     = 8'h14;
   localparam logic [7:0] OFS_FLASH_POWER     = 8'h20;
   localparam logic [7:0] OFS_STOP_REG_SELECT = 8'h24;
   localparam logic [7:0] OFS_STOP_REG_ENABLE = 8'h28;
   localparam logic [7:0] OFS_DEBUG_FREEZE    = 8'h30;
   // power_control fields
   localparam int BIT_WDG_RST_EN    = 0;
   localparam int BIT_STOP_PD_SEL   = 1;
   localparam int BIT_CLR_WAKE      = 2;
   localparam int BIT_CLR_DBGPD     = 3;
   localparam int BIT_DET_EN        = 4;
   localparam int BIT_RST_PIN_POL   = 11;
   localparam int BIT_FILT_CNT_LO   = 17;
   localparam int BIT_FILT_EN       = 25;
   localparam int BIT_DET_IRQ_EN    = 26;
   localparam logic [31:0] RST_POWER_CONTROL = 32'h0000_0601;
   localparam logic [31:0] MSK_POWER_CONTROL = 32'h07fe_0ff3;
   // power_status fields
   localparam int BIT_WAKE_FLAG     = 0;
   localparam int BIT_DBGPD_FLAG    = 1;
   localparam int BIT_DET_OUT       = 2;
   localparam int BIT_WAKE0_EN      = 8;
   localparam int BIT_WAKE1_EN      = 9;
   localparam int BIT_WAKE_POL      = 10;
   localparam logic [31:0] RST_POWER_STATUS  = 32'h0000_0400;
   localparam logic [31:0] MSK_POWER_STATUS  = 32'h0000_0700;
   // other registers
   localparam logic [31:0] RST_VOLTAGE_RESET = 32'h0000_0400;
   localparam logic [31:0] RST_OSC_CONTROL   = 32'h0000_0ea0;
   localparam int BIT_SLOW_OSC_EN   = 7;
   localparam int BIT_FAST_FLASH_WAKE = 0;
   localparam logic [31:0] MSK_FLASH_POWER   = 32'h0000_0007;
   localparam logic [31:0] RST_STOP_REG_SEL  = 32'h0000_0004;
   localparam logic [31:0] MSK_STOP_REG      = 32'h0000_000c;
   localparam int BIT_STOP_REG_LVL  = 2;
   localparam int BIT_DBG_KEEP_STOP = 1;
   localparam int BIT_DBG_KEEP_PD   = 2;
   localparam int BIT_FRZ_WDG       = 5;
   localparam int BIT_FRZ_TIMER_A   = 6;
   localparam int BIT_FRZ_TIMER_B   = 7;
   localparam int BIT_FRZ_WAKE_TMR  = 8;
   localparam logic [31:0] MSK_DEBUG_FREEZE  = 32'h0000_01e6;
   // wake-up regulator and flash start-up times
   localparam int CLK_MHZ           = 100;
   localparam int REG_START_NS      = 2000;
   localparam int FLASH_WAKE_NS     = 3000;
   localparam int FLASH_FAST_NS     = 500;
   localparam int REG_START_CYC  = (REG_START_NS * CLK_MHZ + 999) / 1000;
   localparam int FLASH_WAKE_CYC = (FLASH_WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int FLASH_FAST_CYC = (FLASH_FAST_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W             = 16;

   typedef enum logic [2:0] {
      ST_RUN     = 3'b000,
      ST_DRAIN   = 3'b001,
      ST_STOP    = 3'b010,
      ST_REG_UP  = 3'b011,
      ST_FLASH_UP= 3'b100,
      ST_PD      = 3'b101
   } pm_state_t;
endpackage

// ===== dv/lpm_core_model.sv
/*
 core side of the sleep handshake: deep-sleep bit and wait pulse.
 assumes go_i and deep_i are driven by the bench on clk_i.
*/
`timescale 1ns/10ps
module lpm_core_model (
   input  wire logic clk_i,
   input  wire logic go_i,
   input  wire logic deep_i,
   input  wire logic pend_i,
   output logic      core_wait_o,
   output logic      deep_sleep_request_o
);
   // deep-sleep bit mirrors the core's own control setting
   assign deep_sleep_request_o = deep_i;
   initial core_wait_o = 1'b0;
   // a pending wake source keeps the core running, so no wait
   always @(posedge clk_i) begin
      core_wait_o <= go_i & ~pend_i;
   end
endmodule

// ===== dv/lpm_asserts.sv
/*
 port checker for the power mode controller.
 assumes one clock domain and a bind onto the controller's top module.
*/
`timescale 1ns/10ps
module lpm_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic flash_busy_i,
   input wire logic bus_busy_i,
   input wire logic io_hold_o,
   input wire logic io_float_o,
   input wire logic periph_clk_en_o,
   input wire logic flash_deep_sleep_o,
   input wire logic core_clk_en_o,
   input wire logic fast_internal_osc_en_o,
   input wire logic slow_internal_osc_en_o,
   input wire logic digital_supply_en_o,
   input wire logic core_resume_o,
   input wire logic sysclk_sel_fast_o,
   input wire logic watchdog_run_o,
   input wire logic [3:0] freeze_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus request, then its one-cycle answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_off;
      !periph_clk_en_o && flash_deep_sleep_o;
   endsequence
   property p_ack; s_req |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   // entry lands two cycles after the last idle drain cycle
   property p_stop_drain;
      $rose(io_hold_o) |-> !$past(flash_busy_i, 2) && !$past(bus_busy_i, 2);
   endproperty
   property p_pd_drain;
      $rose(io_float_o) |-> !$past(flash_busy_i, 2) && !$past(bus_busy_i, 2);
   endproperty
   // fast osc stays up exactly when the core clock is kept
   property p_stop_state;
      $rose(io_hold_o) |-> s_off ##0 core_clk_en_o == fast_internal_osc_en_o;
   endproperty
   property p_pd_state;
      $rose(io_float_o) |-> !periph_clk_en_o && (core_clk_en_o ||
         !digital_supply_en_o && !slow_internal_osc_en_o);
   endproperty
   property p_resume;
      core_resume_o |=> periph_clk_en_o && !flash_deep_sleep_o &&
         sysclk_sel_fast_o;
   endproperty
   // only a debug freeze may pause a running watchdog
   property p_wdg;
      watchdog_run_o |=> watchdog_run_o || freeze_o[0];
   endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   a_stop_drain: assert property (p_stop_drain)
      else $error("stop entered while busy");
   a_pd_drain: assert property (p_pd_drain)
      else $error("power-down entered while busy");
   a_stop_state: assert property (p_stop_state)
      else $error("stop outputs wrong");
   a_pd_state: assert property (p_pd_state)
      else $error("power-down outputs wrong");
   a_resume: assert property (p_resume)
      else $error("clocks not restored at resume");
   a_wdg: assert property (p_wdg)
      else $error("watchdog stopped");
endmodule
bind low_power_mode_control lpm_asserts u_lpm_asserts (.*);

// ===== dv/tb.sv
/*
 testbench for the power mode controller: wishbone tasks, stop and
 power-down walks. assumes short wake counts set below.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   $display("[ERR] %s exp %h got %h", n, e, g); n_mismatch++; end end
`define WT(e) begin k = 0; while (!(e) && k < 200) begin \
   @(posedge clk_i); k++; end if (!(e)) begin n_mismatch++; \
   print_verdict(); end end
module tb;
   import lpm_pkg::*;
   localparam int RS = 3, FW = 4, FF = 2;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, q, rdat;
   logic        deep = 0, go = 0, halt = 0, fb = 0, bb = 0;
   logic        iow = 0, tmr = 0, wp0 = 0, ack, wt, dsr;
   logic        det = 0, el, die, ren;
   logic        cke, res, pce, fo, so, ss, fds, ioh, iof, rlp, rlv, dse;
   logic        wdr, por;
   logic [3:0]  frz;
   int          n_mismatch = 0, checked = 0, k, ns, nf;
   logic [7:0]  ofs [6] = '{OFS_POWER_CONTROL, OFS_POWER_STATUS,
      OFS_VOLTAGE_RESET, OFS_OSC_CONTROL, OFS_STOP_REG_SELECT, 8'h40};
   logic [31:0] rv [6] = '{RST_POWER_CONTROL, RST_POWER_STATUS,
      RST_VOLTAGE_RESET, RST_OSC_CONTROL, RST_STOP_REG_SEL, 32'h0};
   initial forever #5 clk_i = ~clk_i;
   lpm_core_model u_lpm_core_model (.clk_i(clk_i), .go_i(go),
      .deep_i(deep), .pend_i(1'b0), .core_wait_o(wt),
      .deep_sleep_request_o(dsr));
   // slow tick, reset pin, second wake pin, sel and pending are tied
   low_power_mode_control #(.REG_START_CYCLES(RS),
      .FLASH_WAKE_CYCLES(FW), .FLASH_FAST_CYCLES(FF)) u_low_power_mode_control (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .deep_sleep_request_i(dsr),
      .core_wait_i(wt), .core_halted_i(halt), .flash_busy_i(fb),
      .bus_busy_i(bb), .io_wake_i(iow), .wake_timer_evt_i(tmr),
      .detector_raw_i(det), .slow_osc_tick_i(1'b0), .reset_pin_i(1'b1),
      .wake_pin0_i(wp0), .wake_pin1_i(1'b0), .core_clk_en_o(cke),
      .core_resume_o(res), .periph_clk_en_o(pce),
      .fast_internal_osc_en_o(fo), .slow_internal_osc_en_o(so),
      .sysclk_sel_fast_o(ss), .flash_deep_sleep_o(fds), .io_hold_o(ioh),
      .io_float_o(iof), .regulator_en_o(ren), .regulator_low_power_o(rlp),
      .regulator_level_o(rlv), .digital_supply_en_o(dse),
      .watchdog_run_o(wdr), .por_request_o(por), .event_line18_o(el),
      .detector_irq_en_o(die), .freeze_o(frz));
   task automatic print_verdict();
      if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one classic cycle, held until ack; entered just after an edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      `WT(ack === 1'b1)
      q = rdat;
      cyc <= 0; stb <= 0;
      @(posedge clk_i);
   endtask
   // select bit through power_control, then one wait pulse; no converter
   // sits behind this block, so bench software leaves it off
   task automatic enter(input logic [31:0] pc);
      xfer(1, OFS_POWER_CONTROL, pc);
      deep <= 1; go <= 1;
      @(posedge clk_i);
      go <= 0;
   endtask
   // wake source held 4 cycles for the synchronisers, count to resume
   task automatic wake(input logic [1:0] s, output int n);
      `WT(ioh === 1'b1)
      {iow, tmr} <= s;
      repeat (4) @(posedge clk_i);
      {iow, tmr} <= 2'b00;
      `WT(res === 1'b1)
      n = k;
      @(posedge clk_i);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      for (int i = 0; i < 6; i++) begin
         xfer(0, ofs[i], 32'h0);
         `CHK("reset value", rv[i], q)
      end
      xfer(1, 8'h40, 32'hffff_ffff);
      xfer(0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, q)
      // detector path: unfiltered, then filtered with no slow ticks
      xfer(1, OFS_POWER_CONTROL, RST_POWER_CONTROL | 32'h0400_0010);
      det <= 1;
      repeat (8) @(posedge clk_i);
      `CHK("event line", 1'b1, el)
      `CHK("det irq en", 1'b1, die)
      det <= 0;
      repeat (8) @(posedge clk_i);
      `CHK("det unfiltered", 1'b0, el)
      xfer(1, OFS_POWER_CONTROL, RST_POWER_CONTROL | 32'h0602_0010);
      det <= 1;
      repeat (8) @(posedge clk_i);
      `CHK("det filtered", 1'b0, el)
      det <= 0;
      fb <= 1;
      enter(RST_POWER_CONTROL);
      repeat (6) @(posedge clk_i);
      `CHK("flash drain", 1'b0, ioh)
      fb <= 0; bb <= 1;
      repeat (6) @(posedge clk_i);
      `CHK("bus drain", 1'b0, ioh)
      bb <= 0;
      `WT(ioh === 1'b1)
      `CHK("periph clk", 1'b0, pce)
      `CHK("flash sleep", 1'b1, fds)
      `CHK("fast osc", 1'b0, fo)
      `CHK("core clk", 1'b0, cke)
      `CHK("slow osc", RST_OSC_CONTROL[BIT_SLOW_OSC_EN], so)
      `CHK("reg lp", 1'b1, rlp)
      `CHK("reg lvl", RST_STOP_REG_SEL[BIT_STOP_REG_LVL], rlv)
      `CHK("watchdog", 1'b1, wdr)
      wake(2'b01, ns);
      `CHK("sysclk", 1'b1, ss)
      `CHK("periph back", 1'b1, pce)
      xfer(0, OFS_POWER_STATUS, 32'h0);
      `CHK("wake flag", RST_POWER_STATUS | 32'h1, q)
      // fast flash wake and slow osc off on the second stop
      xfer(1, OFS_FLASH_POWER, 32'h0000_0001);
      xfer(1, OFS_OSC_CONTROL, 32'h0000_0e20);
      enter(RST_POWER_CONTROL);
      `WT(ioh === 1'b1)
      `CHK("slow osc off", 1'b0, so)
      wake(2'b01, nf);
      `CHK("flash wake", FW - FF, ns - nf)
      xfer(1, OFS_DEBUG_FREEZE, 32'h0000_01e2);
      xfer(0, OFS_DEBUG_FREEZE, 32'h0);
      `CHK("debug reg", 32'h0000_01e2, q)
      halt <= 1;
      repeat (4) @(posedge clk_i);
      `CHK("freeze", 4'hf, frz)
      `CHK("wdg frozen", 1'b0, wdr)
      halt <= 0;
      repeat (4) @(posedge clk_i);
      `CHK("unfreeze", 4'h0, frz)
      enter(RST_POWER_CONTROL);
      `WT(ioh === 1'b1)
      `CHK("keep clk", 1'b1, cke)
      `CHK("keep osc", 1'b1, fo)
      `CHK("keep reg", 1'b1, ren)
      wake(2'b10, ns);
      xfer(1, OFS_DEBUG_FREEZE, 32'h0);
      xfer(1, OFS_POWER_STATUS, 32'h0000_0500);
      bb <= 1;
      enter(RST_POWER_CONTROL | 32'h2);
      repeat (6) @(posedge clk_i);
      `CHK("pd bus drain", 1'b0, iof)
      bb <= 0; fb <= 1;
      repeat (6) @(posedge clk_i);
      `CHK("pd flash drain", 1'b0, iof)
      fb <= 0;
      `WT(iof === 1'b1)
      `CHK("supply", 1'b0, dse)
      `CHK("pd regulator", 1'b0, ren)
      `CHK("pd oscs", 2'b00, {fo, so})
      wp0 <= 1;
      `WT(por === 1'b1)
      rst_i <= 1;
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      xfer(0, OFS_POWER_CONTROL, 32'h0);
      `CHK("pd reset", RST_POWER_CONTROL, q)
      print_verdict();
   end
endmodule
